//--- src/fext_pkg.sv
// Shared constants and types of the extended read status register block
package fext_pkg;

  // Serial opcodes
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_SET_EXT_VOLATILE = 8'h83;
  localparam logic [7:0] OPC_SET_EXT_NONVOLATILE = 8'h85;
  localparam logic [7:0] OPC_CLEAR_EXT_STATUS = 8'h7C;
  localparam logic [7:0] OPC_READ_EXT_STATUS = 8'h7B;

  // Field positions of the extended read status register
  localparam int BIT_WIP = 0;
  localparam int BIT_PROT_ERR = 1;
  localparam int BIT_PGM_ERR = 2;
  localparam int BIT_ERS_ERR = 3;
  localparam int BIT_RSVD = 4;
  localparam int DS_LSB = 5;
  localparam int DS_MSB = 7;
  localparam int DS_W = DS_MSB - DS_LSB + 1;

  // Reset values
  localparam logic [DS_W-1:0] DS_DEFAULT = 3'h7;
  localparam logic RSVD_VALUE = 1'b1;
  localparam logic [7:0] EXT_DEFAULT = 8'hF0;

  // Frame lengths in serial bits
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [4:0] SET_FRAME_BITS = 5'h10;

  // Internal nonvolatile update timing
  localparam int SYS_CLK_MHZ = 50;
  localparam int NV_ERASE_NS = 2000;
  localparam int NV_PROG_NS = 1000;
  localparam int NV_ERASE_CYC = (NV_ERASE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int NV_PROG_CYC = (NV_PROG_NS * SYS_CLK_MHZ + 999) / 1000;

  // Operations reported by the array and register engines
  typedef enum logic [3:0] {
    OP_PAGE_PROGRAM_CMD,
    OP_QUAD_PAGE_PROGRAM_CMD,
    OP_INFO_ROW_PROGRAM_CMD,
    OP_INFO_ROW_ERASE_CMD,
    OP_STATUS_WRITE_CMD,
    OP_AUTOBOOT_WRITE_CMD,
    OP_SET_READ_PARAMS_NONVOLATILE,
    OP_FUNCTION_REG_WRITE_CMD,
    OP_SECTOR_ERASE_CMD,
    OP_BLOCK32_ERASE_CMD,
    OP_BLOCK64_ERASE_CMD,
    OP_CHIP_ERASE_CMD
  } fext_op_t;

  typedef enum logic [1:0] {
    NV_IDLE,
    NV_ERASE,
    NV_PROGRAM
  } fext_nv_state_t;

endpackage

//--- src/fext_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module fext_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Reset, active low
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised copy
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // fext_sync

//--- src/fext_nv_cell.sv
// Nonvolatile drive strength cell with erase then program update
`timescale 1ns/1ps
module fext_nv_cell
  import fext_pkg::*;
#(
  parameter int ERASE_CYC = NV_ERASE_CYC,
  parameter int PROG_CYC = NV_PROG_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic wr_req, // Start an update, one cycle
  input wire logic [DS_W-1:0] wr_data, // New stored value
  input wire logic erase_fault, // Erase phase fails when high
  input wire logic prog_fault, // Program phase fails when high
  output logic [DS_W-1:0] rd_data, // Stored value, registered
  output logic busy, // Update in progress
  output logic erase_err, // Erase phase failed, one cycle
  output logic prog_err // Program phase failed, one cycle
);
  localparam int CW = $clog2(ERASE_CYC + PROG_CYC + 1);

  // Storage survives reset on purpose; only power-up sets it
  logic [DS_W-1:0] cell_q = DS_DEFAULT;
  logic [DS_W-1:0] pend_q;
  logic [CW-1:0] cnt_q;
  fext_nv_state_t st_q;

  assign rd_data = cell_q;
  assign busy = (st_q != NV_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= NV_IDLE;
      cnt_q <= '0;
      pend_q <= DS_DEFAULT;
      erase_err <= 1'b0;
      prog_err <= 1'b0;
    end else begin
      erase_err <= 1'b0;
      prog_err <= 1'b0;
      case (st_q)
        NV_IDLE: begin
          if (wr_req) begin
            st_q <= NV_ERASE;
            pend_q <= wr_data;
            cnt_q <= CW'(ERASE_CYC - 1);
          end
        end
        NV_ERASE: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (erase_fault) begin
            erase_err <= 1'b1;
            st_q <= NV_IDLE;
          end else begin
            st_q <= NV_PROGRAM;
            cnt_q <= CW'(PROG_CYC - 1);
          end
        end
        NV_PROGRAM: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            prog_err <= prog_fault;
            st_q <= NV_IDLE;
          end
        end
        default: st_q <= NV_IDLE;
      endcase
    end
  end

  // Erased cell reads all ones; a failed program leaves it erased
  always_ff @(posedge clk) begin
    if (st_q == NV_ERASE && cnt_q == '0 && !erase_fault) begin
      cell_q <= {DS_W{1'b1}};
    end else if (st_q == NV_PROGRAM && cnt_q == '0 && !prog_fault) begin
      cell_q <= pend_q;
    end
  end
endmodule // fext_nv_cell

//--- src/fext_read_status_reg.sv
// Extended read status register with serial command front end
`timescale 1ns/1ps
// Summary of operation
// - Bits 7:5 select output drive strength
// - Bits 3:0 are read-only status
// - Bit 4 reserved, writes ignored
// - 85h sets nonvolatile, 83h sets volatile
// - Each set command updates only its copy
// - Bit 0 mirrors the busy status bit or a nonvolatile update
// - Protected or locked access sets protection flag
// - Program failure or protection sets program flag
// - Erase or nonvolatile erase-phase failure sets erase flag
// - Protected page program sets program and protection
// - Locked info row program flags both
// - Nonvolatile update flags failing phase
// - Locked status write sets protection and erase
// - Failed function register write sets program
// - Erase fail flags erase; protected adds protection
// - Chip erase with protect bits flags both
// - OTP clear attempts raise no error
// - Read-only data positions silently discarded
// - Error flags sticky until clear or reset
// - Set flags never block later commands
// - Writes need write enable latch set
// - Serial bits arrive MSB first, opcode first
module fext_read_status_reg
  import fext_pkg::*;
#(
  parameter int ERASE_CYC = NV_ERASE_CYC,
  parameter int PROG_CYC = NV_PROG_CYC
) (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic soft_reset, // Software reset pulse
  input wire logic spi_sck, // Serial clock pin
  input wire logic spi_cs_n, // Chip select pin, active low
  input wire logic spi_mosi, // Serial data in pin
  output logic spi_miso_q, // Serial data out
  output logic spi_miso_oe_q, // Data out enable, high drives
  input wire logic wp_n, // Write protect pin, active low
  input wire logic status_write_disable, // Status write disable bit
  input wire logic [3:0] block_protect_bits, // Block protect bits
  input wire logic op_busy, // Status register busy bit
  input wire logic op_done, // Operation finished, one cycle
  input wire fext_op_t op_kind, // Kind of finished operation
  input wire logic op_fail, // Operation failed internally
  input wire logic op_fail_program, // Failing phase was program
  input wire logic op_protected, // Target protected or locked
  input wire logic nv_erase_fault, // Cell erase fault injection
  input wire logic nv_prog_fault, // Cell program fault injection
  output logic [DS_W-1:0] drive_strength_q, // Active drive code
  output logic [3:0] drive_eighths_q, // Drive in eighths, 0 reserved
  output logic [7:0] ext_status_q, // Full register view
  output logic write_enable_latch_q, // Write enable latch
  output logic write_in_progress_q // Busy mirror
);
  logic rst_meta_q;
  logic rst_n_q;
  logic sck_s;
  logic cs_n_s;
  logic mosi_s;
  logic wp_n_s;
  logic sck_prev_q;
  logic cs_n_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic frame_end;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0] opcode_q;
  logic rd_active_q;
  logic [7:0] rd_shift_q;
  logic load_pend_q;
  logic nv_wr_req_q;
  logic [DS_W-1:0] nv_wr_data_q;
  logic [DS_W-1:0] nv_value;
  logic nv_busy;
  logic nv_erase_err;
  logic nv_prog_err;
  logic prot_err_q;
  logic pgm_err_q;
  logic ers_err_q;
  logic [2:0] op_set;
  logic [2:0] flag_set;
  logic flag_clear;
  logic cmd_clear;
  logic cmd_write_enable_cmd;
  logic cmd_wrdi;
  logic cmd_set_vol;
  logic cmd_set_nv;
  logic busy_now;

  // Drive strength code to eighths of full drive
  function automatic logic [3:0] ds_eighths(input logic [DS_W-1:0] c);
    case (c)
      3'h1: ds_eighths = 4'h1;
      3'h2: ds_eighths = 4'h2;
      3'h3: ds_eighths = 4'h3;
      3'h5: ds_eighths = 4'h6;
      3'h6: ds_eighths = 4'h8;
      3'h7: ds_eighths = 4'h4;
      default: ds_eighths = 4'h0;
    endcase
  endfunction

  // Flags raised by a finished operation, as {erase, program, protection}
  function automatic logic [2:0] op_flags(
    input fext_op_t k,
    input logic fail,
    input logic fail_prog,
    input logic prot,
    input logic [3:0] bp,
    input logic sw_locked
  );
    logic [2:0] nvf;
    nvf = {fail & ~fail_prog, fail & fail_prog, 1'b0};
    case (k)
      OP_PAGE_PROGRAM_CMD,
      OP_QUAD_PAGE_PROGRAM_CMD: begin
        op_flags = {1'b0, fail | prot, prot};
      end
      OP_INFO_ROW_PROGRAM_CMD: begin
        op_flags = {1'b0, fail | prot, prot};
      end
      OP_STATUS_WRITE_CMD: begin
        if (sw_locked) begin
          op_flags = 3'h5;
        end else begin
          op_flags = nvf;
        end
      end
      OP_AUTOBOOT_WRITE_CMD,
      OP_SET_READ_PARAMS_NONVOLATILE: begin
        op_flags = nvf;
      end
      OP_FUNCTION_REG_WRITE_CMD: begin
        // OTP clear attempts are not failures
        op_flags = {1'b0, fail, 1'b0};
      end
      OP_SECTOR_ERASE_CMD,
      OP_BLOCK32_ERASE_CMD,
      OP_BLOCK64_ERASE_CMD,
      OP_INFO_ROW_ERASE_CMD: begin
        op_flags = {fail | prot, 1'b0, prot};
      end
      OP_CHIP_ERASE_CMD: begin
        op_flags = {fail | prot | (bp != 4'h0), 1'b0,
                    prot | (bp != 4'h0)};
      end
      default: op_flags = 3'h0;
    endcase
  endfunction

  // Reset release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  fext_sync #(
    .W(4),
    .INIT(4'h5)
  ) u_pin_sync (
    .clk(sys_clk),
    .rst_n(rst_n_q),
    .d({spi_sck, spi_cs_n, spi_mosi, wp_n}),
    .q({sck_s, cs_n_s, mosi_s, wp_n_s})
  );

  fext_nv_cell #(
    .ERASE_CYC(ERASE_CYC),
    .PROG_CYC(PROG_CYC)
  ) u_nv_cell (
    .clk(sys_clk),
    .rst_n(rst_n_q),
    .wr_req(nv_wr_req_q),
    .wr_data(nv_wr_data_q),
    .erase_fault(nv_erase_fault),
    .prog_fault(nv_prog_fault),
    .rd_data(nv_value),
    .busy(nv_busy),
    .erase_err(nv_erase_err),
    .prog_err(nv_prog_err)
  );

  // Edge detection on the sampled serial clock and select
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sck_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_n_prev_q <= cs_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
  assign frame_end = cs_n_s & ~cs_n_prev_q;
  assign busy_now = op_busy | nv_busy;

  // Bit capture, MSB first; counter saturates past a set frame
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
    end else if (cs_n_s) begin
      bit_cnt_q <= 5'h00;
    end else if (sck_rise) begin
      shift_q <= {shift_q[14:0], mosi_s};
      if (bit_cnt_q <= SET_FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Opcode is the first byte of every frame
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      opcode_q <= 8'h00;
    end else if (cs_n_s) begin
      opcode_q <= 8'h00;
    end else if (sck_rise && bit_cnt_q == OPCODE_BITS - 5'h01) begin
      opcode_q <= {shift_q[6:0], mosi_s};
    end
  end

  // Read path: data changes on falling edges, host samples on rising
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_active_q <= 1'b0;
      rd_shift_q <= EXT_DEFAULT;
      spi_miso_q <= 1'b0;
      spi_miso_oe_q <= 1'b0;
    end else if (cs_n_s) begin
      rd_active_q <= 1'b0;
      spi_miso_oe_q <= 1'b0;
      spi_miso_q <= 1'b0;
    end else if (sck_rise && bit_cnt_q == OPCODE_BITS - 5'h01) begin
      rd_active_q <= ({shift_q[6:0], mosi_s} == OPC_READ_EXT_STATUS);
      rd_shift_q <= ext_status_q;
    end else if (sck_fall && rd_active_q) begin
      spi_miso_oe_q <= 1'b1;
      spi_miso_q <= rd_shift_q[7];
      // Rotate rather than reload: a long read repeats
      // the snapshot taken at opcode end
      rd_shift_q <= {rd_shift_q[6:0], rd_shift_q[7]};
    end
  end

  // Commands execute only on a complete frame at select release
  always_comb begin
    cmd_write_enable_cmd = frame_end && bit_cnt_q == OPCODE_BITS &&
               opcode_q == OPC_WRITE_ENABLE;
    cmd_wrdi = frame_end && bit_cnt_q == OPCODE_BITS &&
               opcode_q == OPC_WRITE_DISABLE;
    cmd_clear = frame_end && bit_cnt_q == OPCODE_BITS &&
                opcode_q == OPC_CLEAR_EXT_STATUS;
    // Error flags do not gate these writes
    cmd_set_vol = frame_end && bit_cnt_q == SET_FRAME_BITS &&
                  opcode_q == OPC_SET_EXT_VOLATILE &&
                  write_enable_latch_q && !busy_now;
    cmd_set_nv = frame_end && bit_cnt_q == SET_FRAME_BITS &&
                 opcode_q == OPC_SET_EXT_NONVOLATILE &&
                 write_enable_latch_q && !busy_now;
  end

  // Write enable latch
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      write_enable_latch_q <= 1'b0;
    end else if (soft_reset || cmd_wrdi) begin
      write_enable_latch_q <= 1'b0;
    end else if (cmd_set_vol || cmd_set_nv) begin
      write_enable_latch_q <= 1'b0;
    end else if (cmd_write_enable_cmd) begin
      write_enable_latch_q <= 1'b1;
    end
  end

  // Nonvolatile update request; only the drive field is taken
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nv_wr_req_q <= 1'b0;
      nv_wr_data_q <= DS_DEFAULT;
    end else begin
      nv_wr_req_q <= cmd_set_nv;
      if (cmd_set_nv) begin
        nv_wr_data_q <= shift_q[DS_MSB:DS_LSB];
      end
    end
  end

  // Volatile copy; reload from the cell right after any reset
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      load_pend_q <= 1'b1;
      drive_strength_q <= DS_DEFAULT;
    end else if (load_pend_q || soft_reset) begin
      load_pend_q <= 1'b0;
      drive_strength_q <= nv_value;
    end else if (cmd_set_vol) begin
      drive_strength_q <= shift_q[DS_MSB:DS_LSB];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drive_eighths_q <= 4'h4;
    end else begin
      drive_eighths_q <= ds_eighths(drive_strength_q);
    end
  end

  // Error flag sources
  always_comb begin
    op_set = 3'h0;
    if (op_done) begin
      op_set = op_flags(op_kind, op_fail, op_fail_program, op_protected,
                        block_protect_bits,
                        status_write_disable & ~wp_n_s);
    end
    flag_set = op_set | {nv_erase_err, nv_prog_err, 1'b0};
    flag_clear = cmd_clear | soft_reset;
  end

  // Sticky flags; a new event in the clear cycle still lands
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ers_err_q <= 1'b0;
      pgm_err_q <= 1'b0;
      prot_err_q <= 1'b0;
    end else begin
      ers_err_q <= (ers_err_q & ~flag_clear) | flag_set[2];
      pgm_err_q <= (pgm_err_q & ~flag_clear) | flag_set[1];
      prot_err_q <= (prot_err_q & ~flag_clear) | flag_set[0];
    end
  end

  // Busy mirror and full register view
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      write_in_progress_q <= 1'b0;
      ext_status_q <= EXT_DEFAULT;
    end else begin
      write_in_progress_q <= busy_now;
      ext_status_q[DS_MSB:DS_LSB] <= drive_strength_q;
      ext_status_q[BIT_RSVD] <= RSVD_VALUE;
      ext_status_q[BIT_ERS_ERR] <= ers_err_q;
      ext_status_q[BIT_PGM_ERR] <= pgm_err_q;
      ext_status_q[BIT_PROT_ERR] <= prot_err_q;
      ext_status_q[BIT_WIP] <= busy_now;
    end
  end
endmodule // fext_read_status_reg

//--- test/fext_read_status_reg_props.sv
// Concurrent checks on the extended read status register ports
`timescale 1ns/1ps
module fext_read_status_reg_props
  import fext_pkg::*;
#(
  parameter int ERASE_CYC = NV_ERASE_CYC,
  parameter int PROG_CYC = NV_PROG_CYC
) (
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic soft_reset, // Software reset pulse
  input wire logic spi_cs_n, // Chip select, active low
  input wire logic spi_miso_oe_q, // Data out enable
  input wire logic [3:0] block_protect_bits, // Block protect bits
  input wire logic op_busy, // Busy bit
  input wire logic op_done, // Operation finished
  input wire fext_op_t op_kind, // Kind of finished operation
  input wire logic op_fail, // Operation failed
  input wire logic op_protected, // Target protected
  input wire logic [DS_W-1:0] drive_strength_q, // Active drive code
  input wire logic [3:0] drive_eighths_q, // Decoded drive
  input wire logic [7:0] ext_status_q, // Register view
  input wire logic write_in_progress_q // Busy mirror
);
  localparam logic [3:0] EIGHTHS [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                         4'h0, 4'h6, 4'h8, 4'h4};
  logic [1:0] live_q;
  logic [4:0] quiet_q;
  // Events in the internal reset tail are not judged
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) live_q <= 2'h0;
    else if (live_q != 2'h3) live_q <= live_q + 2'h1;
  end
  // Cycles since the last frame or soft reset that could clear flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) quiet_q <= 5'h00;
    else if (!spi_cs_n || soft_reset) quiet_q <= 5'h00;
    else if (quiet_q != 5'h1F) quiet_q <= quiet_q + 5'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence ev_s(fext_op_t k);
    live_q == 2'h3 && op_done && op_kind == k;
  endsequence
  wip_mirror_a: assert property (live_q == 2'h3 && op_busy |=>
    write_in_progress_q && ext_status_q[BIT_WIP]) else $error("wip lag");
  rsvd_one_a: assert property (ext_status_q[BIT_RSVD])
    else $error("reserved bit low");
  view_drive_a: assert property (
    ext_status_q[DS_MSB:DS_LSB] == $past(drive_strength_q))
    else $error("drive field differs");
  eighths_map_a: assert property (
    drive_eighths_q == EIGHTHS[$past(drive_strength_q)])
    else $error("drive decode wrong");
  prog_prot_a: assert property (ev_s(OP_PAGE_PROGRAM_CMD) ##0
    op_protected |-> ##2 ext_status_q[2:1] == 2'h3)
    else $error("protected program flags");
  chip_lock_a: assert property (ev_s(OP_CHIP_ERASE_CMD) ##0
    block_protect_bits != 4'h0 |-> ##2 ext_status_q[3] && ext_status_q[1])
    else $error("chip erase lock flags");
  erase_fail_a: assert property (ev_s(OP_SECTOR_ERASE_CMD) ##0
    op_fail |-> ##2 ext_status_q[BIT_ERS_ERR]) else $error("erase flag");
  func_fail_a: assert property (ev_s(OP_FUNCTION_REG_WRITE_CMD) ##0
    op_fail |-> ##2 ext_status_q[BIT_PGM_ERR]) else $error("program flag");
  flag_hold_a: assert property (
    |($past(ext_status_q[3:1]) & ~ext_status_q[3:1]) |-> quiet_q < 5'h0A)
    else $error("flag dropped");
  oe_idle_a: assert property (spi_cs_n [*6] |-> !spi_miso_oe_q)
    else $error("data out driven while deselected");
endmodule // fext_read_status_reg_props
bind fext_read_status_reg fext_read_status_reg_props #(
  .ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) fext_read_status_reg_props_i (
  .sys_clk, .arst_n, .soft_reset, .spi_cs_n, .spi_miso_oe_q,
  .block_protect_bits, .op_busy, .op_done, .op_kind, .op_fail, .op_protected,
  .drive_strength_q, .drive_eighths_q, .ext_status_q, .write_in_progress_q);

//--- test/fext_host_model.sv
// Host serial controller model for the link pins
`timescale 1ns/1ps
module fext_host_model (
  input wire logic clk, // Pacing clock
  output logic sck, // Serial clock, idle low
  output logic cs_n, // Chip select, active low
  output logic mosi, // Serial data out of the host
  input wire logic miso, // Serial data into the host
  input wire logic miso_oe // Device drives miso when high
);
  logic [7:0] rd_q;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rd_q = 8'h00;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Sends n bits from bit 15 down, then reads rn bits; half in clk cycles
  task automatic frame(input logic [15:0] w, input int n, input int rn,
                       input int half);
    cs_n = 1'b0;
    for (int i = 0; i < n + rn; i++) begin
      mosi = (i < n) ? w[15-i] : ~mosi;
      wait_clk(half);
      sck = 1'b1;
      if (i >= n) rd_q = {rd_q[6:0], miso_oe ? miso : 1'bx};
      wait_clk(half);
      sck = 1'b0;
    end
    wait_clk(half);
    cs_n = 1'b1;
    // Released line must not keep looking valid
    mosi = ~mosi;
    wait_clk(4 * half);
  endtask
endmodule // fext_host_model

//--- test/tb_top.sv
// Self-checking bench for the extended read status register block
`timescale 1ns/1ps
module tb_top;
  import fext_pkg::*;
  localparam logic [3:0] EIGHTHS [8] = '{4'h0, 4'h1, 4'h2, 4'h3,
                                         4'h0, 4'h6, 4'h8, 4'h4};
  logic sys_clk, arst_n, soft_reset, spi_sck, spi_cs_n, spi_mosi, wp_n;
  logic spi_miso_q, spi_miso_oe_q, status_write_disable, op_busy, op_done;
  logic op_fail, op_fail_program, op_protected, nv_erase_fault;
  logic nv_prog_fault, write_enable_latch_q, write_in_progress_q;
  logic [3:0] block_protect_bits, drive_eighths_q;
  logic [DS_W-1:0] drive_strength_q, drive_e;
  logic [7:0] ext_status_q;
  logic [2:0] flags_e;
  logic [31:0] seed;
  fext_op_t op_kind;
  int mismatches, check_count, cyc;
  fext_read_status_reg #(.ERASE_CYC(3), .PROG_CYC(2)) fext_read_status_reg_i (
    .sys_clk, .arst_n, .soft_reset, .spi_sck, .spi_cs_n, .spi_mosi,
    .spi_miso_q, .spi_miso_oe_q, .wp_n, .status_write_disable,
    .block_protect_bits, .op_busy, .op_done, .op_kind, .op_fail,
    .op_fail_program, .op_protected, .nv_erase_fault, .nv_prog_fault,
    .drive_strength_q, .drive_eighths_q, .ext_status_q,
    .write_enable_latch_q, .write_in_progress_q);
  fext_host_model fext_host_model_i (.clk(sys_clk), .sck(spi_sck),
    .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso_q),
    .miso_oe(spi_miso_oe_q));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [7:0] exp_ext();
    return {drive_e, 1'b1, flags_e, 1'b0};
  endfunction
  // Returns {erase, program, protection} for one finished operation
  function automatic logic [2:0] exp_flags(input fext_op_t k, input logic f,
      input logic fp, input logic pr, input logic lk, input logic [3:0] bp);
    case (k)
      OP_PAGE_PROGRAM_CMD, OP_QUAD_PAGE_PROGRAM_CMD, OP_INFO_ROW_PROGRAM_CMD:
        return {1'b0, f | pr, pr};
      OP_STATUS_WRITE_CMD, OP_AUTOBOOT_WRITE_CMD,
      OP_SET_READ_PARAMS_NONVOLATILE: begin
        if (lk && k == OP_STATUS_WRITE_CMD) return 3'h5;
        return {f & ~fp, f & fp, 1'b0};
      end
      OP_FUNCTION_REG_WRITE_CMD: return {1'b0, f, 1'b0};
      OP_CHIP_ERASE_CMD: return {f | pr | (|bp), 1'b0, pr | (|bp)};
      default: return {f | pr, 1'b0, pr};
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk_all();
    chk_reg(ext_status_q, exp_ext());
    chk_reg({4'h0, drive_eighths_q}, {4'h0, EIGHTHS[drive_e]});
  endtask
  task automatic cmd8(input logic [7:0] opc);
    fext_host_model_i.frame({opc, 8'h00}, 8, 0, 4);
  endtask
  task automatic set_ds(input logic [7:0] opc, input logic [7:0] d,
                        input logic we);
    if (we) cmd8(OPC_WRITE_ENABLE);
    fext_host_model_i.frame({opc, d}, 16, 0, 4);
  endtask
  task automatic read_chk(input int half);
    fext_host_model_i.frame({OPC_READ_EXT_STATUS, 8'h00}, 8, 8, half);
    chk_reg(fext_host_model_i.rd_q, exp_ext());
  endtask
  task automatic op_event(input logic [31:0] r);
    fext_op_t k;
    k = fext_op_t'(r[3:0] % 4'hC);
    wp_n = r[4];
    status_write_disable = r[5];
    block_protect_bits = r[10] ? r[9:6] : 4'h0;
    op_fail = r[11];
    op_fail_program = r[12];
    op_protected = r[13] & r[14];
    // Lets the protect pin pass its synchroniser
    tick(4);
    op_kind = k;
    op_done = 1'b1;
    tick(1);
    op_done = 1'b0;
    flags_e |= exp_flags(k, r[11], r[12], r[13] & r[14],
                         r[5] & ~r[4], block_protect_bits);
    tick(2);
    chk_all();
  endtask
  task automatic reset_pulse(input logic hard);
    if (hard) arst_n = 1'b0;
    else soft_reset = 1'b1;
    tick(hard ? 2 : 1);
    arst_n = 1'b1;
    soft_reset = 1'b0;
    tick(8);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    {arst_n, soft_reset, status_write_disable, op_busy, op_done} = 5'h00;
    {op_fail, op_fail_program, op_protected, nv_erase_fault} = 4'h0;
    {wp_n, nv_prog_fault, block_protect_bits} = 6'h20;
    op_kind = OP_PAGE_PROGRAM_CMD;
    {mismatches, check_count, cyc} = {32'h0, 32'h0, 32'h0};
    {drive_e, flags_e, seed} = {3'h7, 3'h0, 32'hBE1C79AE};
    tick(12);
    arst_n = 1'b1;
    tick(8);
    chk_all();
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      set_ds(OPC_SET_EXT_VOLATILE, {c[2:0], seed[4:0]}, 1'b1);
      drive_e = c[2:0];
      chk_all();
      chk_bit(write_enable_latch_q, 1'b0);
    end
    set_ds(OPC_SET_EXT_VOLATILE, 8'h20, 1'b0);
    chk_all();
    op_event(32'h6000);
    op_event(32'h044B);
    op_event(32'h0808);
    op_event(32'h0807);
    op_event(32'h0024);
    for (int k = 0; k < 12; k++) op_event(32'h0800 | k);
    set_ds(OPC_SET_EXT_VOLATILE, 8'hA3, 1'b1);
    drive_e = 3'h5;
    chk_all();
    read_chk(8);
    repeat (30) begin
      seed = xs(seed);
      case (seed[17:16])
        2'h0: begin
          cmd8(OPC_CLEAR_EXT_STATUS);
          flags_e = 3'h0;
          chk_all();
        end
        2'h1: begin
          set_ds(OPC_SET_EXT_VOLATILE, seed[31:24], 1'b1);
          drive_e = seed[31:29];
          chk_all();
        end
        default: op_event(seed);
      endcase
      read_chk(seed[18] ? 4 : 8);
    end
    op_busy = 1'b1;
    set_ds(OPC_SET_EXT_VOLATILE, 8'h40, 1'b1);
    chk_reg(ext_status_q, exp_ext() | 8'h01);
    chk_bit(write_in_progress_q, 1'b1);
    op_busy = 1'b0;
    cmd8(OPC_WRITE_DISABLE);
    chk_bit(write_enable_latch_q, 1'b0);
    reset_pulse(1'b0);
    {drive_e, flags_e} = {3'h7, 3'h0};
    set_ds(OPC_SET_EXT_NONVOLATILE, 8'h5F, 1'b1);
    chk_all();
    nv_erase_fault = 1'b1;
    set_ds(OPC_SET_EXT_NONVOLATILE, 8'hC0, 1'b1);
    nv_erase_fault = 1'b0;
    flags_e = 3'h4;
    chk_all();
    reset_pulse(1'b1);
    {drive_e, flags_e} = {3'h2, 3'h0};
    chk_all();
    nv_prog_fault = 1'b1;
    set_ds(OPC_SET_EXT_NONVOLATILE, 8'h20, 1'b1);
    nv_prog_fault = 1'b0;
    flags_e = 3'h2;
    chk_all();
    reset_pulse(1'b0);
    {drive_e, flags_e} = {3'h7, 3'h0};
    chk_all();
    finish_test();
  end
endmodule // tb_top
